// *** src/bic_pkg.sv ***
package bic_pkg;
  localparam int NCH = 6;
  localparam int AW = 15;
  localparam int DW = 48;
  // control word layout: current address high, terminal address low
  localparam int CUR_LSB = 15;
  localparam int TERM_LSB = 0;
  localparam logic [14:0] CW_LO = 15'h0001;
  localparam logic [14:0] CW_HI = 15'h0006;
  localparam logic [2:0] SCAN_FIRST = 3'h1;
  localparam logic [2:0] BLK_CH = 3'h7;

  typedef enum logic [2:0] {SV_IDLE, SV_LOAD, SV_MEM, SV_UPD, SV_DONE} bic_sv_t;
  typedef enum logic [2:0] {BT_IDLE, BT_IWAIT, BT_IMEM, BT_IDROP, BT_ORD, BT_OGAP, BT_OHOLD} bic_bt_t;

  // one-bit-change order over channels 1,3,2,6,4,5
  function automatic logic [2:0] scan_next(input logic [2:0] c);
    unique case (c)
      3'h1: scan_next = 3'h3;
      3'h3: scan_next = 3'h2;
      3'h2: scan_next = 3'h6;
      3'h6: scan_next = 3'h4;
      3'h4: scan_next = 3'h5;
      default: scan_next = 3'h1;
    endcase
  endfunction
endpackage

// *** src/bic_core.sv ***
// How it works
// [RULE1] activation sets active; next odd phase raises that channel's action request
// [RULE2] scanner is a two-rank 3-bit counter, one bit changing per step
// [RULE3] scanner stops on a requesting channel; rank two updates only without requests; here only a request at rank one holds it
// [RULE4] advance stage toggles each odd phase, copied on even, then next odd
// [RULE5] first and third advance stages equal means stopped: raise word service request
// [RULE6] service request copies scanner number into channel select register
// [RULE7] service marks storage busy, loads compare word, addresses storage at current
// [RULE8] after storage access current address plus one is written back
// [RULE9] end: input clears wait, output sets it; clear request; deactivate when done
// [RULE10] output wait flag drives output ready to peripheral
// [RULE11] output resume sets resume seen, clears wait, drops output ready
// [RULE12] falling resume clears resume seen and allows a new request
// [RULE13] input ready must be present before an input channel is serviced
// [RULE14] current address 1..6 also references that channel's control word
// [RULE15] control word out takes address fields from channel; in stores them too
// [RULE16] block transfers use channel 7 and halt all but running buffers
// [RULE17] block count from index, first word at base+count-1, address decrements
// [RULE18] block input waits for input ready, then stores the channel 7 word
// [RULE19] per input word raise resume, drop it after ready falls, until count zero
// [RULE20] interrupt request during block input stops loop, count kept unchanged
// [RULE21] block output first word goes at once; later wait resume seen and removed
// [RULE22] output word on lines then ready; drop ready on resume; exit at count end
// [RULE23] control word holds current address high and terminal address low
// [RULE24] activation picks channel 1..6 and loads its current address
// [RULE25] odd and even phase enables come from the one clock
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
module bic_core #(
  parameter int NCH = bic_pkg::NCH,
  parameter int AW = bic_pkg::AW,
  parameter int DW = bic_pkg::DW
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic act_stb,
  input wire logic [2:0] act_chan,
  input wire logic act_out,
  input wire logic [AW-1:0] act_addr,
  input wire logic term_stb,
  input wire logic [2:0] term_chan,
  input wire logic [AW-1:0] term_addr,
  input wire logic [NCH:1] in_ready,
  input wire logic [NCH*DW-1:0] in_data,
  output logic [NCH:1] in_resume,
  output logic [NCH:1] out_ready,
  output logic [NCH*DW-1:0] out_data,
  input wire logic [NCH:1] out_resume,
  output logic [NCH:1] chan_active,
  output logic storage_busy,
  output logic mem_req,
  output logic mem_we,
  output logic [AW-1:0] mem_addr,
  output logic [DW-1:0] mem_wdata,
  input wire logic [DW-1:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic bt_start,
  input wire logic bt_out,
  input wire logic [AW-1:0] bt_base,
  input wire logic [AW-1:0] bt_count,
  input wire logic [DW-1:0] bt_in_data,
  input wire logic bt_in_ready,
  output logic bt_in_resume,
  input wire logic bt_out_resume,
  output logic bt_out_ready,
  output logic [DW-1:0] bt_out_data,
  input wire logic bt_irq,
  output logic bt_busy,
  output logic bt_halted,
  output logic [AW-1:0] bt_remain
);
  if (NCH != 6 || AW < 3 || DW <= bic_pkg::CUR_LSB + AW || bic_pkg::CUR_LSB != AW
    || bic_pkg::TERM_LSB != 0) begin : g_chk
    $error("bic_core: unsupported channel count or widths");
  end

  logic rst_s1, rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // pin inputs through two flops; the first rank feeds only the second
  localparam int SW = 2 * NCH + 2;
  logic [SW-1:0] pin_s1, pin_s2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {bt_out_resume, bt_in_ready, out_resume, in_ready};
      pin_s2 <= pin_s1;
    end
  end
  wire [NCH:1] in_rdy_s = pin_s2[NCH-1:0];
  wire [NCH:1] out_res_s = pin_s2[2*NCH-1:NCH];
  wire bt_in_rdy_s = pin_s2[2*NCH];
  wire bt_out_res_s = pin_s2[2*NCH+1];

  logic phase_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) phase_reg <= 1'b0;
    else phase_reg <= ~phase_reg; // see [RULE25]
  end
  wire odd_en = phase_reg;
  wire even_en = ~phase_reg;

  logic [NCH:1] active_reg, areq_reg, wait_reg, seen_reg, dir_reg;
  logic [AW-1:0] cur_reg [1:NCH];
  logic [AW-1:0] term_reg [1:NCH];
  logic [DW-1:0] oword_reg [1:NCH];
  bic_pkg::bic_sv_t sv_state;
  bic_pkg::bic_bt_t bt_state;

  // scanner
  logic [2:0] rank1_reg, rank2_reg, sel_reg;
  logic adv1_reg, adv2_reg, adv3_reg, wsr_reg;
  wire stop_here = areq_reg[rank1_reg];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rank1_reg <= bic_pkg::SCAN_FIRST;
      rank2_reg <= bic_pkg::SCAN_FIRST;
      adv1_reg <= 1'b0;
      adv2_reg <= 1'b0;
      adv3_reg <= 1'b0;
      wsr_reg <= 1'b0;
    end else begin
      if (odd_en && !stop_here && !wsr_reg) begin
        rank1_reg <= bic_pkg::scan_next(rank2_reg); // see [RULE2]
        adv1_reg <= ~adv1_reg; // see [RULE4]
      end
      // gate on the request at rank one only, else another channel's request freezes the scan
      if (even_en && !stop_here) rank2_reg <= rank1_reg; // see [RULE3]
      if (even_en) adv2_reg <= adv1_reg;
      if (odd_en) adv3_reg <= adv2_reg;
      if (sv_state == bic_pkg::SV_DONE) wsr_reg <= 1'b0; // see [RULE9]
      else if (odd_en && stop_here && adv1_reg == adv3_reg) wsr_reg <= 1'b1; // see [RULE5]
    end
  end

  // word service
  logic [AW-1:0] ccw_cur, svc_addr;
  logic svc_req, svc_we, fast_reg;
  logic [DW-1:0] svc_wdata;
  logic bt_req;
  wire sel_out = dir_reg[sel_reg];
  wire [AW-1:0] sel_cur = cur_reg[sel_reg];
  wire is_cw = sel_cur >= bic_pkg::CW_LO && sel_cur <= bic_pkg::CW_HI;
  wire [2:0] cw_ch = ccw_cur[2:0];
  wire [DW-1:0] sel_in = in_data[(sel_reg-3'h1)*DW +: DW];
  wire [AW-1:0] cur_inc = ccw_cur + AW'(1);
  wire [DW-1:0] rd_merged = fast_reg ? {mem_rdata[DW-1:bic_pkg::CUR_LSB+AW], cur_reg[cw_ch], term_reg[cw_ch]}
    : mem_rdata;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sv_state <= bic_pkg::SV_IDLE;
      sel_reg <= bic_pkg::SCAN_FIRST;
      ccw_cur <= '0;
      svc_req <= 1'b0;
      svc_we <= 1'b0;
      svc_addr <= '0;
      svc_wdata <= '0;
      fast_reg <= 1'b0;
    end else begin
      unique case (sv_state)
        bic_pkg::SV_IDLE: if (wsr_reg) begin
          sel_reg <= rank1_reg; // see [RULE6]
          sv_state <= bic_pkg::SV_LOAD;
        end
        bic_pkg::SV_LOAD: if (!bt_req) begin
          ccw_cur <= sel_cur; // see [RULE7]
          fast_reg <= is_cw; // see [RULE14]
          svc_req <= 1'b1;
          svc_we <= ~sel_out;
          svc_addr <= sel_cur;
          svc_wdata <= sel_in;
          sv_state <= bic_pkg::SV_MEM;
        end
        bic_pkg::SV_MEM: if (mem_ack) begin
          svc_req <= 1'b0;
          sv_state <= bic_pkg::SV_UPD;
        end
        bic_pkg::SV_UPD: sv_state <= bic_pkg::SV_DONE;
        bic_pkg::SV_DONE: sv_state <= bic_pkg::SV_IDLE;
      endcase
    end
  end

  // output word registers; control words take their address fields from the channel registers
  always_ff @(posedge clk) begin
    if (sv_state == bic_pkg::SV_MEM && mem_ack && sel_out) oword_reg[sel_reg] <= rd_merged; // see [RULE15]
  end

  // per-channel flags and control words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= '0;
      areq_reg <= '0;
      wait_reg <= '0;
      seen_reg <= '0;
      dir_reg <= '0;
      for (int i = 1; i <= NCH; i++) begin
        cur_reg[i] <= '0;
        term_reg[i] <= '0;
      end
    end else begin
      for (int i = 1; i <= NCH; i++) begin
        if (act_stb && act_chan == 3'(i) && !bt_busy) begin
          active_reg[i] <= 1'b1; // see [RULE24]
          cur_reg[i] <= act_addr;
          dir_reg[i] <= act_out;
          wait_reg[i] <= 1'b0;
          seen_reg[i] <= 1'b0;
        end
        if (term_stb && term_chan == 3'(i)) term_reg[i] <= term_addr;
        if (odd_en) begin
          // input channels also need ready before asking
          if (active_reg[i] && !areq_reg[i] && !wait_reg[i] && !seen_reg[i] && (dir_reg[i] || in_rdy_s[i]))
            areq_reg[i] <= 1'b1; // see [RULE1] [RULE12] [RULE13]
          if (dir_reg[i] && wait_reg[i] && out_res_s[i]) begin
            seen_reg[i] <= 1'b1; // see [RULE11]
            wait_reg[i] <= 1'b0;
          end
          if (seen_reg[i] && !wait_reg[i] && !(dir_reg[i] ? out_res_s[i] : in_rdy_s[i]))
            seen_reg[i] <= 1'b0; // see [RULE12]
        end
        if (sv_state == bic_pkg::SV_UPD) begin
          if (fast_reg && !sel_out && cw_ch == 3'(i)) begin
            cur_reg[i] <= svc_wdata[bic_pkg::CUR_LSB +: AW]; // see [RULE15]
            term_reg[i] <= svc_wdata[bic_pkg::TERM_LSB +: AW];
          end
          if (sel_reg == 3'(i)) cur_reg[i] <= cur_inc; // see [RULE8] [RULE23]
        end
        if (sv_state == bic_pkg::SV_DONE && sel_reg == 3'(i)) begin
          areq_reg[i] <= 1'b0; // see [RULE9]
          if (dir_reg[i]) wait_reg[i] <= 1'b1; // see [RULE10]
          else seen_reg[i] <= 1'b1;
          if (cur_reg[i] == term_reg[i]) active_reg[i] <= 1'b0; // see [RULE23]
        end
      end
    end
  end

  always_comb begin
    for (int i = 1; i <= NCH; i++) out_data[(i-1)*DW +: DW] = oword_reg[i];
  end
  assign out_ready = wait_reg & dir_reg; // see [RULE10]
  assign in_resume = seen_reg & ~dir_reg;
  assign chan_active = active_reg;
  assign storage_busy = sv_state != bic_pkg::SV_IDLE; // see [RULE7]

  // block transfer on channel 7; the processor stalls while busy
  logic [AW-1:0] bt_addr, bt_rem;
  logic bt_we, bt_first, bt_in_res_reg, bt_out_rdy_reg, bt_halt_reg;
  logic [DW-1:0] bt_wdata, bt_word, bt_odata;
  wire sv_free = sv_state == bic_pkg::SV_IDLE && !wsr_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bt_state <= bic_pkg::BT_IDLE;
      bt_addr <= '0;
      bt_rem <= '0;
      bt_req <= 1'b0;
      bt_we <= 1'b0;
      bt_wdata <= '0;
      bt_word <= '0;
      bt_odata <= '0;
      bt_first <= 1'b0;
      bt_in_res_reg <= 1'b0;
      bt_out_rdy_reg <= 1'b0;
      bt_halt_reg <= 1'b0;
    end else begin
      unique case (bt_state)
        bic_pkg::BT_IDLE: if (bt_start && bt_count != '0) begin
          bt_addr <= bt_base + bt_count - AW'(1); // see [RULE17]
          bt_rem <= bt_count;
          bt_first <= 1'b1;
          bt_halt_reg <= 1'b0;
          bt_state <= bt_out ? bic_pkg::BT_ORD : bic_pkg::BT_IWAIT; // see [RULE16]
        end
        bic_pkg::BT_IWAIT: if (bt_irq) begin
          bt_halt_reg <= 1'b1; // see [RULE20]
          bt_state <= bic_pkg::BT_IDLE;
        end else if (bt_in_rdy_s && sv_free) begin
          bt_req <= 1'b1; // see [RULE18]
          bt_we <= 1'b1;
          bt_wdata <= bt_in_data;
          bt_state <= bic_pkg::BT_IMEM;
        end
        bic_pkg::BT_IMEM: if (mem_ack) begin
          bt_req <= 1'b0;
          bt_in_res_reg <= 1'b1; // see [RULE19]
          bt_rem <= bt_rem - AW'(1);
          bt_addr <= bt_addr - AW'(1);
          bt_state <= bic_pkg::BT_IDROP;
        end
        bic_pkg::BT_IDROP: if (!bt_in_rdy_s) begin
          bt_in_res_reg <= 1'b0; // see [RULE19]
          bt_state <= bt_rem == '0 ? bic_pkg::BT_IDLE : bic_pkg::BT_IWAIT;
        end
        bic_pkg::BT_ORD: if (bt_req && mem_ack) begin
          bt_req <= 1'b0;
          bt_word <= mem_rdata;
          bt_state <= bic_pkg::BT_OGAP;
        end else if (!bt_req && sv_free) begin
          bt_req <= 1'b1;
          bt_we <= 1'b0;
        end
        // later words wait until the previous resume has gone away
        bic_pkg::BT_OGAP: if (bt_first || !bt_out_res_s) begin
          bt_odata <= bt_word; // see [RULE21] [RULE22]
          bt_out_rdy_reg <= 1'b1;
          bt_first <= 1'b0;
          bt_rem <= bt_rem - AW'(1);
          bt_addr <= bt_addr - AW'(1);
          bt_state <= bic_pkg::BT_OHOLD;
        end
        bic_pkg::BT_OHOLD: if (bt_out_res_s) begin
          bt_out_rdy_reg <= 1'b0; // see [RULE22]
          bt_state <= bt_rem == '0 ? bic_pkg::BT_IDLE : bic_pkg::BT_ORD;
        end
        default: bt_state <= bic_pkg::BT_IDLE;
      endcase
    end
  end

  // only one side holds a request at a time, so a plain select suffices
  assign mem_req = svc_req | bt_req;
  assign mem_we = svc_req ? svc_we : bt_we;
  assign mem_addr = svc_req ? svc_addr : bt_addr;
  assign mem_wdata = svc_req ? svc_wdata : bt_wdata;
  assign bt_in_resume = bt_in_res_reg;
  assign bt_out_ready = bt_out_rdy_reg;
  assign bt_out_data = bt_odata;
  assign bt_busy = bt_state != bic_pkg::BT_IDLE; // see [RULE16]
  assign bt_halted = bt_halt_reg;
  assign bt_remain = bt_rem;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_stop_seen;
    odd_en && stop_here && adv1_reg == adv3_reg && !wsr_reg && sv_state == bic_pkg::SV_IDLE;
  endsequence
  sequence s_svc_load;
    sv_state == bic_pkg::SV_LOAD && !bt_req;
  endsequence

  a_scan_one_bit: assert property ($countones(rank1_reg ^ $past(rank1_reg)) <= 1) // see [RULE2]
    else $error("scanner changed more than one bit");
  a_scan_stops: assert property (stop_here && !wsr_reg |=> rank1_reg == $past(rank1_reg)) // see [RULE3]
    else $error("scanner advanced past a request");
  a_adv_toggle: assert property (odd_en && !stop_here && !wsr_reg |=> adv1_reg != $past(adv1_reg)) // see [RULE4]
    else $error("advance stage did not toggle");
  a_stop_request: assert property (s_stop_seen |=> wsr_reg) // see [RULE5]
    else $error("stopped scanner raised no service request");
  a_sel_copy: assert property (sv_state == bic_pkg::SV_IDLE && wsr_reg |=> sel_reg == $past(rank1_reg)) // see [RULE6]
    else $error("channel select not loaded from scanner");
  a_svc_addr: assert property (s_svc_load |=> mem_req && mem_addr == $past(sel_cur) && storage_busy) // see [RULE7]
    else $error("service did not address current word");
  a_cur_incr: assert property (sv_state == bic_pkg::SV_UPD |=> cur_reg[sel_reg] == $past(cur_inc)) // see [RULE8]
    else $error("current address not advanced by one");
  a_out_wait_set: assert property (sv_state == bic_pkg::SV_DONE && sel_out |=> out_ready[sel_reg] && !wsr_reg) // see [RULE9]
    else $error("output channel not waiting after service");
  a_resume_seen: assert property (odd_en && out_ready[sel_reg] && out_res_s[sel_reg] // see [RULE11]
    |=> !out_ready[sel_reg] && seen_reg[sel_reg])
    else $error("output resume not taken");
  a_bt_first: assert property (bt_state == bic_pkg::BT_IDLE && bt_start && bt_count != '0 // see [RULE17]
    |=> bt_addr == $past(bt_base) + $past(bt_count) - AW'(1) ##1 bt_busy)
    else $error("block transfer first address wrong");
  a_bt_irq_keep: assert property (bt_state == bic_pkg::BT_IWAIT && bt_irq
    |=> bt_halted && !bt_busy && bt_remain == $past(bt_remain)) // see [RULE20]
    else $error("interrupted block input changed count");
  a_bt_ready_drop: assert property (bt_state == bic_pkg::BT_OHOLD && bt_out_res_s |=> !bt_out_ready) // see [RULE22]
    else $error("output ready not dropped on resume");
endmodule

// *** tb/bic_periph.sv ***
`timescale 1ns/100ps
module bic_periph (
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic [7:1] in_en,
  input wire logic [7:1] in_rsm,
  input wire logic [7:1] out_rdy,
  output logic [7:1] in_rdy,
  output logic [7*bic_pkg::DW-1:0] in_word,
  output logic [7:1] out_rsm
);
  // index 7 stands for the block transfer channel
  logic [3:0] osh [1:7];
  logic [7:0] seq [1:7];
  logic [bic_pkg::DW-1:0] last [1:7];
  always_ff @(posedge clk or negedge rstn) begin
    for (int i = 1; i <= 7; i++) begin
      if (!rstn) begin
        osh[i] <= 4'h0;
        seq[i] <= 8'h00;
        in_rdy[i] <= 1'b0;
        last[i] <= '0;
      end else begin
        osh[i] <= {osh[i][2:0], out_rdy[i]};
        if (in_rdy[i] && in_rsm[i]) begin
          in_rdy[i] <= 1'b0;
          seq[i] <= seq[i] + 8'h01;
        end else if (!in_en[i]) begin
          in_rdy[i] <= 1'b0;
        end else if (!in_rdy[i] && !in_rsm[i]) begin
          in_rdy[i] <= 1'b1;
          last[i] <= {16'hc0de, 16'h0000, 5'h00, 3'(i), seq[i]};
        end
      end
    end
  end
  // released lines show the inverse, so a stale word cannot pass for a fresh one
  always_comb begin
    for (int i = 1; i <= 7; i++) begin
      in_word[(i-1)*bic_pkg::DW +: bic_pkg::DW] = in_rdy[i] ? last[i] : ~last[i];
      out_rsm[i] = slow ? osh[i][3] : osh[i][0];
    end
  end
endmodule

// *** tb/tb_bic_core.sv ***
`timescale 1ns/100ps
module tb_bic_core;
  logic clk, rstn, act_stb, act_out, term_stb, mem_ack, bt_start, bt_out, bt_irq, slow;
  logic [2:0] act_chan, term_chan;
  logic [14:0] act_addr, term_addr, bt_base, bt_count, mem_addr, bt_remain;
  logic [6:1] in_resume, out_ready, chan_active;
  logic [287:0] out_data;
  logic [47:0] mem_rdata, mem_wdata, bt_out_data;
  logic storage_busy, mem_req, mem_we, bt_in_resume, bt_out_ready, bt_busy, bt_halted;
  logic [7:1] in_en, p_rdy, p_rsm;
  logic [335:0] p_word;
  logic [47:0] mem [0:63];
  int err_total, n_compared;
  bic_core dut_u (.clk(clk), .rstn(rstn), .act_stb(act_stb), .act_chan(act_chan), .act_out(act_out),
    .act_addr(act_addr), .term_stb(term_stb), .term_chan(term_chan), .term_addr(term_addr),
    .in_ready(p_rdy[6:1]), .in_data(p_word[287:0]), .in_resume(in_resume), .out_ready(out_ready),
    .out_data(out_data), .out_resume(p_rsm[6:1]), .chan_active(chan_active), .storage_busy(storage_busy),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .bt_start(bt_start), .bt_out(bt_out), .bt_base(bt_base), .bt_count(bt_count),
    .bt_in_data(p_word[335:288]), .bt_in_ready(p_rdy[7]), .bt_in_resume(bt_in_resume),
    .bt_out_resume(p_rsm[7]), .bt_out_ready(bt_out_ready), .bt_out_data(bt_out_data), .bt_irq(bt_irq),
    .bt_busy(bt_busy), .bt_halted(bt_halted), .bt_remain(bt_remain));
  bic_periph periph_u (.clk(clk), .rstn(rstn), .slow(slow), .in_en(in_en),
    .in_rsm({bt_in_resume, in_resume}), .out_rdy({bt_out_ready, out_ready}), .in_rdy(p_rdy),
    .in_word(p_word), .out_rsm(p_rsm));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [47:0] init_w(input logic [5:0] a);
    return 48'h5a5a_0000_0000 | {42'h0, a};
  endfunction
  function automatic logic [47:0] dev_w(input logic [2:0] c, input logic [7:0] s);
    return {16'hc0de, 16'h0000, 5'h00, c, s};
  endfunction
  // storage answers one cycle after the request, never stalls longer
  always @(posedge clk) begin
    mem_ack <= mem_req && !mem_ack;
    if (mem_req && !mem_ack) begin
      mem_rdata <= mem[mem_addr[5:0]];
      if (mem_we) mem[mem_addr[5:0]] <= mem_wdata;
    end
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic probe(input int k);
    if (k <= 6) return out_ready[k];
    if (k == 7) return bt_out_ready;
    if (k == 8) return bt_busy;
    return chan_active[k-8];
  endfunction
  // bounded wait; running out of cycles counts as a mismatch
  task automatic wait_for(input int k, input logic lvl);
    int n;
    n = 0;
    while (probe(k) !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 3000) begin
        err_total++;
        $display("Error at %0t: wait %0d timed out", $time, k);
        report_and_stop();
      end
    end
  endtask
  task automatic act(input logic [2:0] ch, input logic o, input logic [14:0] a, input logic [14:0] t);
    @(posedge clk);
    term_stb <= 1'b1;
    term_chan <= ch;
    term_addr <= t;
    @(posedge clk);
    term_stb <= 1'b0;
    act_stb <= 1'b1;
    act_chan <= ch;
    act_out <= o;
    act_addr <= a;
    @(posedge clk);
    act_stb <= 1'b0;
    #1;
  endtask
  task automatic bt_go(input logic o, input logic [14:0] b, input logic [14:0] c);
    @(posedge clk);
    bt_start <= 1'b1;
    bt_out <= o;
    bt_base <= b;
    bt_count <= c;
    @(posedge clk);
    bt_start <= 1'b0;
    #1;
    check(bt_busy, 1'b1);
  endtask
  initial begin
    {rstn, act_stb, act_out, term_stb, mem_ack, bt_start, bt_out, bt_irq, slow} = '0;
    {act_chan, term_chan, act_addr, term_addr, bt_base, bt_count, mem_rdata} = '0;
    in_en = '0;
    err_total = 0;
    n_compared = 0;
    for (int a = 0; a < 64; a++) mem[a] = init_w(6'(a));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    // output buffer, slow peripheral: three words, address steps up
    slow <= 1'b1;
    act(3'h2, 1'b1, 15'h0010, 15'h0013);
    check(chan_active[2], 1'b1);
    for (int k = 0; k < 3; k++) begin
      wait_for(2, 1'b1);
      check(out_data[48 +: 48], init_w(6'(16 + k)));
      if (k == 0) check(chan_active[2], 1'b1);
      wait_for(2, 1'b0);
    end
    wait_for(10, 1'b0);
    // control word output: address fields come from channel 2 registers
    slow <= 1'b0;
    act(3'h4, 1'b1, 15'h0002, 15'h0003);
    wait_for(4, 1'b1);
    check(out_data[144 +: 48], (init_w(6'h02) & ~48'h0000_3fff_ffff) | {18'h0, 15'h0013, 15'h0013});
    wait_for(12, 1'b0);
    // input buffer, fast peripheral
    in_en[5] <= 1'b1;
    act(3'h5, 1'b0, 15'h0020, 15'h0023);
    wait_for(13, 1'b0);
    in_en[5] <= 1'b0;
    for (int k = 0; k < 3; k++) check(mem[32 + k], dev_w(3'h5, 8'(k)));
    // block input: highest address first; activation refused meanwhile
    in_en[7] <= 1'b1;
    bt_go(1'b0, 15'h0030, 15'h0003);
    act(3'h6, 1'b1, 15'h0004, 15'h0005);
    check(chan_active[6], 1'b0);
    wait_for(8, 1'b0);
    in_en[7] <= 1'b0;
    for (int k = 0; k < 3; k++) check(mem[50 - k], dev_w(3'h7, 8'(k)));
    check(bt_remain, 15'h0000);
    // block output: second word waits for the resume to come and go
    slow <= 1'b1;
    bt_go(1'b1, 15'h0008, 15'h0002);
    for (int k = 0; k < 2; k++) begin
      wait_for(7, 1'b1);
      check(bt_out_data, init_w(6'(9 - k)));
      wait_for(7, 1'b0);
    end
    wait_for(8, 1'b0);
    // block input cut short by an interrupt request
    repeat (10) @(posedge clk);
    bt_go(1'b0, 15'h0038, 15'h0003);
    repeat (10) @(posedge clk);
    bt_irq <= 1'b1;
    wait_for(8, 1'b0);
    @(posedge clk);
    bt_irq <= 1'b0;
    check(bt_halted, 1'b1);
    check(bt_remain, 15'h0003);
    check(mem[58], init_w(6'h3a));
    report_and_stop();
  end
endmodule
